/* bpcp_capture_port.sv */
// post code capture port: host byte capture, time tagging, queue and ec registers
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// queue with flip-flop storage, valid/ready on both sides
module bpcp_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 16,
	parameter int LW = 5
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// control
	input wire logic i_flush,
	// filling side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	// draining side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data,
	output logic [LW-1:0] o_level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] rd_ptr;
		logic [AW-1:0] wr_ptr;
		logic [LW-1:0] level;
	} bpcp_fifo_state_t;

	bpcp_fifo_state_t st_r;
	bpcp_fifo_state_t st_nxt;
	logic push;
	logic pop;

	// pointers wrap by overflow, so depth must be a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || LW < $clog2(DEPTH + 1))
	begin : g_bad_depth
		$error("bpcp_fifo: unsupported DEPTH or LW");
	end

	// a full queue still accepts when the head leaves in the same cycle
	assign o_out_valid = (st_r.level != '0);
	assign o_in_ready = (st_r.level != LW'(DEPTH)) || i_out_ready;
	assign o_out_data = st_r.mem[st_r.rd_ptr];
	assign o_level = st_r.level;
	assign pop = o_out_valid && i_out_ready;
	assign push = i_in_valid && o_in_ready;

	// next state; flush drops everything including a same-cycle push
	always_comb
	begin
		st_nxt = st_r;
		if (i_flush)
		begin
			st_nxt.rd_ptr = '0;
			st_nxt.wr_ptr = '0;
			st_nxt.level = '0;
		end
		else
		begin
			if (push)
			begin
				st_nxt.mem[st_r.wr_ptr] = i_in_data;
				st_nxt.wr_ptr = st_r.wr_ptr + AW'(1);
			end
			if (pop)
				st_nxt.rd_ptr = st_r.rd_ptr + AW'(1);
			if (push && !pop)
				st_nxt.level = st_r.level + LW'(1);
			else if (pop && !push)
				st_nxt.level = st_r.level - LW'(1);
		end
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule

// ==========================================================
// top of the capture port
// Contract
// - inactive: no claim, flush, zero, stop timer
// - configuration kept regardless of activation bit
// - activation via host index 30h, ec 330h
// - accepted byte plus timestamp pushed, 16 deep
// - full queue drops oldest; host reads zero
// - ec map 100h/104h/108h/10Ch, host 00h
// - threshold codes give 1, 4, 8, 14
// - irq while active and level reaches threshold
// - timer counts only while enable bit set
// - tick rate clock over 8/16/32/64
// - writing one to bit 2 clears timer
// - ec write of zero to 10Ch or 330h clears the timer
// - writing one to bit 1 flushes queue
// - status bit 1 flags write while full
// - status bit 0 shows queue not empty
// - count register loads and reads timer
module bpcp_capture_port #(
	parameter int DEPTH = bpcp_pkg::QUEUE_DEPTH
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// host i/o capture port, byte wide
	input wire logic i_host_wr,
	input wire logic i_host_rd,
	input wire logic [7:0] i_host_addr,
	input wire logic [7:0] i_host_wdata,
	output logic o_host_claim,
	output logic [7:0] o_host_rdata,
	// host configuration port
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_index,
	input wire logic [7:0] i_cfg_wdata,
	output logic [7:0] o_cfg_rdata,
	// ec register port
	input wire logic i_ec_wr,
	input wire logic i_ec_rd,
	input wire logic [11:0] i_ec_addr,
	input wire logic [3:0] i_ec_be,
	input wire logic [31:0] i_ec_wdata,
	output logic [31:0] o_ec_rdata,
	output logic o_ec_rvalid,
	// interrupt level to the aggregator
	output logic o_fill_level_irq
);
	typedef struct packed {
		bpcp_pkg::bpcp_cfg_t cfg;
		logic active;
		logic overrun;
		logic [bpcp_pkg::TS_W-1:0] ts;
		logic [bpcp_pkg::PRESC_W-1:0] presc;
		logic [31:0] ec_rdata;
		logic ec_rvalid;
		logic [7:0] cfg_rdata;
	} bpcp_state_t;

	bpcp_state_t st_r;
	bpcp_state_t st_nxt;
	logic [1:0] rst_sync_r;
	logic rst_n_int;
	logic host_take;
	logic ec_cfg_wr;
	logic ec_cnt_wr;
	logic ec_act_wr;
	logic q_pop;
	logic q_flush;
	logic q_in_ready;
	logic q_out_valid;
	bpcp_pkg::bpcp_entry_t q_in;
	bpcp_pkg::bpcp_entry_t q_out;
	logic [bpcp_pkg::LEVEL_W-1:0] q_level;
	logic [bpcp_pkg::LEVEL_W-1:0] thr_level;
	logic [bpcp_pkg::PRESC_W-1:0] presc_last;
	logic [31:0] cnt_merged;
	logic [31:0] cfg_word;
	logic [31:0] sts_word;

	if (DEPTH < int'(bpcp_pkg::THR_CODE3))
	begin : g_bad_depth
		$error("bpcp_capture_port: DEPTH below highest threshold");
	end

	// ==========================================================
	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n_int = rst_sync_r[1];

	// ==========================================================
	// access decode; the host only ever sees byte cycles here
	assign host_take = i_host_wr && st_r.active && (i_host_addr == bpcp_pkg::HOST_OFF_CAPTURE);
	assign o_host_claim = host_take;
	assign ec_cfg_wr = i_ec_wr && (i_ec_addr == bpcp_pkg::EC_OFF_CONFIG) && i_ec_be[0];
	assign ec_cnt_wr = i_ec_wr && (i_ec_addr == bpcp_pkg::EC_OFF_COUNT) && (i_ec_be[3:1] != 3'h0);
	assign ec_act_wr = i_ec_wr && (i_ec_addr == bpcp_pkg::EC_OFF_ACTIVATE) && i_ec_be[0];
	assign q_pop = i_ec_rd && (i_ec_addr == bpcp_pkg::EC_OFF_QUEUE) && q_out_valid;

	// flush by software, or continuously while the block is off
	assign q_flush = !st_r.active || (ec_cfg_wr && i_ec_wdata[bpcp_pkg::CFG_FLUSH_BIT]);

	// ==========================================================
	// capture queue; a full queue frees its head so the new byte lands
	assign q_in.entry_time_tag = st_r.ts;
	assign q_in.queued_byte = i_host_wdata;

	bpcp_fifo #(
		.W(bpcp_pkg::ENTRY_W),
		.DEPTH(DEPTH),
		.LW(bpcp_pkg::LEVEL_W)
	) u_queue (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n_int),
		.i_flush(q_flush),
		.i_in_valid(host_take),
		.o_in_ready(q_in_ready),
		.i_in_data(q_in),
		.o_out_valid(q_out_valid),
		.i_out_ready(q_pop || (host_take && q_level == bpcp_pkg::LEVEL_W'(DEPTH))),
		.o_out_data(q_out),
		.o_level(q_level)
	);

	// ==========================================================
	// threshold lookup and interrupt level
	always_comb
	begin
		unique case (st_r.cfg.thr_sel)
			2'h0: thr_level = bpcp_pkg::THR_CODE0;
			2'h1: thr_level = bpcp_pkg::THR_CODE1;
			2'h2: thr_level = bpcp_pkg::THR_CODE2;
			2'h3: thr_level = bpcp_pkg::THR_CODE3;
		endcase
	end
	assign o_fill_level_irq = st_r.active && (q_level >= thr_level);

	// last prescaler count for the selected division
	assign presc_last = bpcp_pkg::PRESC_W'((bpcp_pkg::DIV_BASE << st_r.cfg.tick_divider_sel) - 1);

	// count register write merges enabled bytes into the timer field
	always_comb
	begin
		cnt_merged = {st_r.ts, 8'h00};
		for (int b = 1; b < 4; b++)
		begin
			if (i_ec_be[b])
				cnt_merged[8*b +: 8] = i_ec_wdata[8*b +: 8];
		end
	end

	// read views; self-clearing command bits always read zero
	assign cfg_word = {24'h000000, st_r.cfg, 3'h0};
	assign sts_word = {30'h0, st_r.overrun, q_out_valid};

	// ==========================================================
	// next state of controls, timer and read data
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ec_rvalid = i_ec_rd;
		st_nxt.ec_rdata = 32'h00000000;
		st_nxt.cfg_rdata = 8'h00;

		// configuration is written independent of activation
		if (ec_cfg_wr)
			st_nxt.cfg = i_ec_wdata[bpcp_pkg::CFG_DIV_LSB +: 5];

		// activation from either the ec map or the host config port
		if (ec_act_wr)
			st_nxt.active = i_ec_wdata[bpcp_pkg::ACT_BIT];
		else if (i_cfg_wr && i_cfg_index == bpcp_pkg::HOST_IDX_ACTIVATE)
			st_nxt.active = i_cfg_wdata[bpcp_pkg::ACT_BIT];

		// overrun is sticky; a write while full beats a flush
		if (q_flush)
			st_nxt.overrun = 1'b0;
		if (host_take && q_level == bpcp_pkg::LEVEL_W'(DEPTH))
			st_nxt.overrun = 1'b1;

		// timer: software load or clear wins over the tick
		if (st_r.active && st_r.cfg.timer_en)
		begin
			if (st_r.presc == presc_last)
			begin
				st_nxt.presc = '0;
				st_nxt.ts = st_r.ts + bpcp_pkg::TS_W'(1);
			end
			else
				st_nxt.presc = st_r.presc + bpcp_pkg::PRESC_W'(1);
		end
		if (ec_cnt_wr)
			st_nxt.ts = cnt_merged[bpcp_pkg::COUNT_LSB +: bpcp_pkg::TS_W];
		if (ec_cfg_wr && i_ec_wdata[bpcp_pkg::CFG_CLR_TS_BIT])
		begin
			st_nxt.ts = '0;
			st_nxt.presc = '0;
		end
		if (!st_r.active)
		begin
			st_nxt.ts = '0;
			st_nxt.presc = '0;
		end

		// ec read mux, answered one cycle after the strobe
		if (i_ec_rd)
		begin
			unique case (i_ec_addr)
				bpcp_pkg::EC_OFF_QUEUE: st_nxt.ec_rdata = q_out_valid ? q_out : 32'h00000000;
				bpcp_pkg::EC_OFF_CONFIG: st_nxt.ec_rdata = cfg_word;
				bpcp_pkg::EC_OFF_STATUS: st_nxt.ec_rdata = sts_word;
				bpcp_pkg::EC_OFF_COUNT: st_nxt.ec_rdata = {st_r.ts, 8'h00};
				bpcp_pkg::EC_OFF_ACTIVATE: st_nxt.ec_rdata = {31'h0, st_r.active};
				default: st_nxt.ec_rdata = 32'h00000000;
			endcase
		end

		// host configuration port read
		if (i_cfg_rd && i_cfg_index == bpcp_pkg::HOST_IDX_ACTIVATE)
			st_nxt.cfg_rdata = {7'h00, st_r.active};
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			st_r <= '0;
			st_r.cfg <= bpcp_pkg::CFG_RESET[bpcp_pkg::CFG_DIV_LSB +: 5];
			st_r.active <= bpcp_pkg::ACT_RESET;
		end
		else
			st_r <= st_nxt;
	end

	// outputs; host reads of the capture register are always zero
	assign o_host_rdata = 8'h00;
	assign o_ec_rdata = st_r.ec_rdata;
	assign o_ec_rvalid = st_r.ec_rvalid;
	assign o_cfg_rdata = st_r.cfg_rdata;
endmodule

`default_nettype wire

/* bpcp_capture_port_props.sv */
// assertions on the capture port's ports
`timescale 1ns/1ps
`default_nettype none
module bpcp_capture_port_props (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// watched ports
	input wire logic i_host_wr,
	input wire logic [7:0] i_host_addr,
	input wire logic o_host_claim,
	input wire logic [7:0] o_host_rdata,
	input wire logic i_ec_wr,
	input wire logic i_ec_rd,
	input wire logic [11:0] i_ec_addr,
	input wire logic [31:0] o_ec_rdata,
	input wire logic o_ec_rvalid,
	input wire logic o_fill_level_irq
);
	// ==========================================================
	// single domain, so clock and reset are given once
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	rd_answer_a: assert property (i_ec_rd |=> o_ec_rvalid)
		else $error("read got no answer");
	rd_quiet_a: assert property (!i_ec_rd |=> !o_ec_rvalid && o_ec_rdata == 32'h0)
		else $error("answer without a read");
	host_zero_a: assert property (o_host_rdata == 8'h00)
		else $error("host read not zero");
	claim_cause_a: assert property (o_host_claim |-> i_host_wr && i_host_addr == 8'h00)
		else $error("claim without capture write");
	cfg_wo_a: assert property (i_ec_rd && i_ec_addr == 12'h104 |=> o_ec_rdata[2:1] == 2'h0)
		else $error("write-only bits read back");
	sts_res_a: assert property (i_ec_rd && i_ec_addr == 12'h108 |=> o_ec_rdata[31:2] == 30'h0)
		else $error("status reserved bits set");
	cnt_low_a: assert property (i_ec_rd && i_ec_addr == 12'h10C |=> o_ec_rdata[7:0] == 8'h00)
		else $error("count low byte set");
	map_hole_a: assert property (i_ec_rd && !(i_ec_addr inside {12'h100, 12'h104, 12'h108,
		12'h10C, 12'h330}) |=> o_ec_rdata == 32'h0)
		else $error("unmapped read not zero");
	irq_cause_a: assert property ($rose(o_fill_level_irq) |-> $past(o_host_claim) || $past(i_ec_wr))
		else $error("irq rose without cause");
endmodule
`default_nettype wire

/* bpcp_host_model.sv */
// host model: byte-wide i/o writes to the capture port
`timescale 1ns/1ps
`default_nettype none
module bpcp_host_model (
	// clock
	input wire logic i_clk_sys,
	// request from the bench
	input wire logic i_send,
	input wire logic [7:0] i_byte,
	// host bus
	output logic o_host_wr,
	output logic [7:0] o_host_addr,
	output logic [7:0] o_host_wdata
);
	initial
	begin
		o_host_wr = 1'b0;
		o_host_addr = 8'h00;
		o_host_wdata = 8'h00;
	end
	// one byte cycle per send; idle data toggles so stale bytes never pass as valid
	always @(posedge i_clk_sys)
	begin
		o_host_wr <= i_send;
		o_host_addr <= i_send ? 8'h00 : 8'h5A;
		o_host_wdata <= i_send ? i_byte : ~o_host_wdata;
	end
endmodule
`default_nettype wire

/* bpcp_pkg.sv */
// shared constants and carrier types for the post code capture port
package bpcp_pkg;

	// ==========================================================
	// register map
	localparam logic [11:0] EC_OFF_QUEUE = 12'h100;
	localparam logic [11:0] EC_OFF_CONFIG = 12'h104;
	localparam logic [11:0] EC_OFF_STATUS = 12'h108;
	localparam logic [11:0] EC_OFF_COUNT = 12'h10C;
	localparam logic [11:0] EC_OFF_ACTIVATE = 12'h330;
	localparam logic [7:0] HOST_OFF_CAPTURE = 8'h00;
	localparam logic [7:0] HOST_IDX_ACTIVATE = 8'h30;

	// ==========================================================
	// field positions
	localparam int CFG_THR_LSB = 6;
	localparam int CFG_TIMER_EN_BIT = 5;
	localparam int CFG_DIV_LSB = 3;
	localparam int CFG_CLR_TS_BIT = 2;
	localparam int CFG_FLUSH_BIT = 1;
	localparam int STS_OVERRUN_BIT = 1;
	localparam int STS_NOT_EMPTY_BIT = 0;
	localparam int COUNT_LSB = 8;
	localparam int ACT_BIT = 0;

	// ==========================================================
	// reset values and sizes
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic ACT_RESET = 1'b0;
	localparam int TS_W = 24;
	localparam int BYTE_W = 8;
	localparam int ENTRY_W = TS_W + BYTE_W;
	localparam int QUEUE_DEPTH = 16;
	localparam int LEVEL_W = 5;

	// ==========================================================
	// threshold levels per code 0..3
	localparam logic [LEVEL_W-1:0] THR_CODE0 = 5'h01;
	localparam logic [LEVEL_W-1:0] THR_CODE1 = 5'h04;
	localparam logic [LEVEL_W-1:0] THR_CODE2 = 5'h08;
	localparam logic [LEVEL_W-1:0] THR_CODE3 = 5'h0E;

	// tick divider base: code n divides the clock by DIV_BASE << n
	localparam int DIV_BASE = 8;
	localparam int PRESC_W = 6;

	// one queue entry: time tag above, host byte below
	typedef struct packed {
		logic [TS_W-1:0] entry_time_tag;
		logic [BYTE_W-1:0] queued_byte;
	} bpcp_entry_t;

	// software controls held in the configuration register
	typedef struct packed {
		logic [1:0] thr_sel;
		logic timer_en;
		logic [1:0] tick_divider_sel;
	} bpcp_cfg_t;

endpackage

/* tb_bios_post_code_capture_port.sv */
// testbench: ec read scoreboard, host model and checker
`timescale 1ns/1ps
`default_nettype none
module tb_bios_post_code_capture_port;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic send = 1'b0;
	logic host_rd = 1'b0;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic ec_wr = 1'b0;
	logic ec_rd = 1'b0;
	logic [7:0] hbyte = 8'h00;
	logic [7:0] cfg_idx = 8'h00;
	logic [7:0] cfg_wd = 8'h00;
	logic [11:0] ec_addr = 12'h000;
	logic [31:0] ec_wd = 32'h0;
	logic host_wr, claim, irq, rvalid;
	logic [7:0] haddr, hwdata, hrdata, cfg_rdata, b[17];
	logic [31:0] rdata, exp_q[$];
	logic [23:0] v;
	int thr[4] = '{1, 4, 8, 14};
	int d, miscompares = 0, num_checks = 0;
	int n_claims = 0;

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	bpcp_host_model u_host (.i_clk_sys(clk), .i_send(send), .i_byte(hbyte),
		.o_host_wr(host_wr), .o_host_addr(haddr), .o_host_wdata(hwdata));

	bpcp_capture_port #(.DEPTH(16)) DUT (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_host_wr(host_wr), .i_host_rd(host_rd), .i_host_addr(haddr),
		.i_host_wdata(hwdata), .o_host_claim(claim), .o_host_rdata(hrdata),
		.i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd), .i_cfg_index(cfg_idx),
		.i_cfg_wdata(cfg_wd), .o_cfg_rdata(cfg_rdata), .i_ec_wr(ec_wr),
		.i_ec_rd(ec_rd), .i_ec_addr(ec_addr), .i_ec_be(4'hF), .i_ec_wdata(ec_wd),
		.o_ec_rdata(rdata), .o_ec_rvalid(rvalid), .o_fill_level_irq(irq));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// one ec access; the strobe drops for a cycle between accesses
	task automatic ec_op(input logic w, input logic [11:0] a, input logic [31:0] dd);
		@(posedge clk);
		ec_wr <= w;
		ec_rd <= !w;
		ec_addr <= a;
		ec_wd <= dd;
		@(posedge clk);
		ec_wr <= 1'b0;
		ec_rd <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		ec_op(1'b0, a, 32'h0);
	endtask

	task automatic host(input logic [7:0] x);
		@(posedge clk);
		send <= 1'b1;
		hbyte <= x;
		host_rd <= 1'($urandom);
		@(posedge clk);
		send <= 1'b0;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic summarize;
		$display("checks %0d, miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// scoreboard: each read answer against the oldest note
	always @(posedge clk)
	begin
		if (rvalid === 1'b1)
			check(rdata, exp_q.pop_front());
	end

	// every claimed host byte is counted once, at the edge that takes it
	always @(posedge clk)
	begin
		if (claim === 1'b1)
			n_claims++;
	end

	initial
	begin
		void'($urandom(85562));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(12'h104, 32'h0);
		rd(12'h10C, 32'h0);
		rd(12'h330, 32'h0);
		host(8'hA5);
		rd(12'h108, 32'h0);
		// activate through the host configuration port
		@(posedge clk);
		cfg_idx <= 8'h30;
		cfg_wd <= 8'h01;
		cfg_wr <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b1;
		@(posedge clk);
		cfg_rd <= 1'b0;
		#1;
		check({24'h0, cfg_rdata}, 32'h1);
		rd(12'h330, 32'h1);
		// every threshold: low one entry short, high at the level
		foreach (thr[c])
		begin
			ec_op(1'b1, 12'h104, 32'h2 | 32'(c << 6));
			for (int i = 1; i < thr[c]; i++)
				host(8'($urandom));
			settle();
			check(32'(irq), 32'h0);
			host(8'($urandom));
			settle();
			check(32'(irq), 32'h1);
		end
		ec_op(1'b1, 12'h104, 32'h2);
		rd(12'h108, 32'h0);
		v = 24'($urandom) | 24'h1;
		ec_op(1'b1, 12'h10C, {v, 8'h00});
		rd(12'h10C, {v, 8'h00});
		host(8'h3C);
		rd(12'h100, {v, 8'h3C});
		rd(12'h108, 32'h0);
		ec_op(1'b1, 12'h10C, 32'h0);
		rd(12'h10C, 32'h0);
		ec_op(1'b1, 12'h10C, {v, 8'h00});
		ec_op(1'b1, 12'h104, 32'h4);
		rd(12'h10C, 32'h0);
		rd(12'h104, 32'h0);
		// tick rate: timer runs 3.5 ticks from activation, then is frozen
		for (int s = 0; s < 4; s++)
		begin
			d = 8 << s;
			ec_op(1'b1, 12'h330, 32'h0);
			ec_op(1'b1, 12'h104, 32'(32 | s << 3));
			rd(12'h10C, 32'h0);
			ec_op(1'b1, 12'h330, 32'h1);
			repeat (3 * d + d / 2) @(posedge clk);
			ec_op(1'b1, 12'h104, 32'(s << 3));
			repeat (70) @(posedge clk);
			rd(12'h10C, 32'h300);
		end
		// overrun: seventeen writes push out the oldest
		ec_op(1'b1, 12'h10C, 32'h0);
		ec_op(1'b1, 12'h104, 32'h2);
		foreach (b[i])
		begin
			b[i] = 8'($urandom);
			host(b[i]);
		end
		rd(12'h108, 32'h3);
		for (int i = 1; i < 17; i++)
			rd(12'h100, {24'h0, b[i]});
		rd(12'h108, 32'h2);
		rd(12'h100, 32'h0);
		rd(12'h200, 32'h0);
		// deactivation flushes but keeps the configuration
		ec_op(1'b1, 12'h104, 32'hFA);
		host(8'h11);
		ec_op(1'b1, 12'h330, 32'h0);
		host(8'h22);
		rd(12'h108, 32'h0);
		rd(12'h104, 32'hF8);
		settle();
		check(32'(exp_q.size()), 32'h0);
		check(32'(n_claims), 32'h2E);
		check({24'h0, hrdata}, 32'h0);
		summarize();
	end

	// watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end
endmodule

bind bpcp_capture_port bpcp_capture_port_props u_props (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .i_host_wr(i_host_wr), .i_host_addr(i_host_addr),
	.o_host_claim(o_host_claim), .o_host_rdata(o_host_rdata), .i_ec_wr(i_ec_wr),
	.i_ec_rd(i_ec_rd), .i_ec_addr(i_ec_addr), .o_ec_rdata(o_ec_rdata),
	.o_ec_rvalid(o_ec_rvalid), .o_fill_level_irq(o_fill_level_irq));
`default_nettype wire
